// *** logic/alzl_core.sv ***
// ambient light sampling, averaging, zone hysteresis and zone target selection
//
// How it works
// - five zones split by four upper and four lower threshold registers.
// - each threshold is 8 bits, full code equals 2V, 7.843mV per step.
// - rising level moves up past a boundary only above that boundary's upper value.
// - falling level moves down only below that boundary's lower value.
// - three per-zone target sets; set one to bank 1, two/three to B-F.
// - each target is an 8-bit fraction of bank full-scale current.
// - per-zone enable lets the PWM duty scale that zone's target.
// - config bit 1 picks analog (0) or PWM (1) sensor mode.
// - analog mode offers 128 resistor settings, one of them high impedance.
// - converter gives 8-bit code, 0xFF meaning 2V.
// - PWM mode forces resistor to high impedance regardless of select.
// - converter runs only while enabled, sampling continuously at 7.142ksps.
// - raw sample register at 0x37 refreshes every 140us while enabled.
// - average is mean of period samples, period from config bits 5:3.
// - average register at 0x38 updates once per averaging period.
// - each period end latches the zone of the averaged level.
// - zone starts at zone 0 when sensing starts.
// - startup uses a fast 1.1ms averaging period.
// - fast startup lasts three fast periods, then programmed period applies.
`timescale 1ns/10ps
`default_nettype none
`include "alzl_regs.svh"

module alzl_core
  import alzl_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_we,
  input  wire logic       reg_re,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] conv_code,
  output logic            conv_run,
  output logic            sample_stb,
  output logic      [6:0] gain_res_sel,
  output logic            pwm_sense_mode,
  output logic      [2:0] zone,
  output logic            zone_stb,
  output logic            zone_pwm_scale,
  output logic      [7:0] target_set_one,
  output logic      [7:0] target_set_two,
  output logic      [7:0] target_set_three,
  output logic      [2:0] set_two_bank,
  output logic      [2:0] set_three_bank
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] base,
                                    input logic [7:0] len);
    return (a >= base) && (a < base + len);
  endfunction : in_range

  function automatic logic [2:0] zone_next(input logic [2:0]  prev,
                                           input logic [7:0]  lvl,
                                           input alzl_bound_t hi,
                                           input alzl_bound_t lo);
    logic [2:0] z;
    z = prev;
    for (int i = 0; i < 4; i++)
    begin
      if (z < `ALZL_TOP_ZONE && lvl > hi[z[1:0]])
        z = z + 3'h1;
    end
    if (z == prev)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (z > 3'h0 && lvl < lo[2'(z - 3'h1)])
          z = z - 3'h1;
      end
    end
    return z;
  endfunction : zone_next

  // ----------------------------------------------------------------
  // converter input synchroniser
  // ----------------------------------------------------------------
  logic [7:0] code_m_q, code_s_q;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      code_m_q <= 8'h00;
      code_s_q <= 8'h00;
    end
    else
    begin
      code_m_q <= conv_code;
      code_s_q <= code_m_q;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  alzl_cfg_t    cfg_q, cfg_d;
  logic [6:0]   res_q, res_d;
  logic [4:0]   pwmz_q, pwmz_d;
  logic [7:0]   asg_q, asg_d;
  alzl_bound_t  hi_q, hi_d, lo_q, lo_d;
  logic [7:0]   rdata_d;
  logic         tgt_we;
  logic [3:0]   tgt_waddr;
  alzl_result_t res_out_q, res_out_d;

  always_comb
  begin
    cfg_d     = cfg_q;
    res_d     = res_q;
    pwmz_d    = pwmz_q;
    asg_d     = asg_q;
    hi_d      = hi_q;
    lo_d      = lo_q;
    tgt_we    = reg_we && in_range(reg_addr, `ALZL_OFS_TGT_BASE, `ALZL_TGT_ENTRIES);
    tgt_waddr = 4'(reg_addr - `ALZL_OFS_TGT_BASE);
    if (reg_we)
    begin
      unique case (reg_addr)
        `ALZL_OFS_CFG:
        begin
          cfg_d.enable   = reg_wdata[`ALZL_CFG_EN_BIT];
          cfg_d.pwm_mode = reg_wdata[`ALZL_CFG_PWM_BIT];
          cfg_d.avg_sel  = reg_wdata[`ALZL_CFG_AVG_MSB:`ALZL_CFG_AVG_LSB];
        end
        `ALZL_OFS_RES_SEL:    res_d  = reg_wdata[6:0];
        `ALZL_OFS_PWM_ZONE:   pwmz_d = reg_wdata[4:0];
        `ALZL_OFS_SET_ASSIGN: asg_d  = reg_wdata;
        default:;
      endcase
      for (int i = 0; i < 4; i++)
      begin
        if (reg_addr == `ALZL_OFS_HI_BASE + 8'(i))
          hi_d[i] = reg_wdata;
        if (reg_addr == `ALZL_OFS_LO_BASE + 8'(i))
          lo_d[i] = reg_wdata;
      end
    end
    rdata_d = 8'h00;
    if (reg_re)
    begin
      unique case (reg_addr)
        `ALZL_OFS_CFG:        rdata_d = {2'h0, cfg_q.avg_sel, 1'b0, cfg_q.pwm_mode,
                                         cfg_q.enable};
        `ALZL_OFS_RES_SEL:    rdata_d = {1'b0, res_q};
        `ALZL_OFS_PWM_ZONE:   rdata_d = {3'h0, pwmz_q};
        `ALZL_OFS_SET_ASSIGN: rdata_d = asg_q;
        `ALZL_OFS_RAW:        rdata_d = res_out_q.raw;
        `ALZL_OFS_AVG:        rdata_d = res_out_q.avg;
        `ALZL_OFS_ZONE:       rdata_d = {5'h00, res_out_q.zone};
        default:
        begin
          for (int i = 0; i < 4; i++)
          begin
            if (reg_addr == `ALZL_OFS_HI_BASE + 8'(i))
              rdata_d = hi_q[i];
            if (reg_addr == `ALZL_OFS_LO_BASE + 8'(i))
              rdata_d = lo_q[i];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q     <= alzl_cfg_t'(5'h00);
      res_q     <= `ALZL_RES_RESET;
      pwmz_q    <= 5'h00;
      asg_q     <= `ALZL_ASSIGN_RESET;
      hi_q      <= '0;
      lo_q      <= '0;
      reg_rdata <= 8'h00;
    end
    else
    begin
      cfg_q     <= cfg_d;
      res_q     <= res_d;
      pwmz_q    <= pwmz_d;
      asg_q     <= asg_d;
      hi_q      <= hi_d;
      lo_q      <= lo_d;
      reg_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // sampling, averaging and zone tracking
  // ----------------------------------------------------------------
  alzl_state_t st_q, st_d;
  logic [10:0] tick_q, tick_d;
  logic [11:0] scnt_q, scnt_d;
  logic [18:0] sum_q, sum_d;
  logic [1:0]  fast_q, fast_d;
  logic        tick, pend, zstb_d;
  logic [3:0]  shift;
  logic [18:0] sum_all;
  logic [7:0]  avg_val;

  assign tick    = (st_q != ST_OFF) && (tick_q == 11'(`ALZL_SAMPLE_CYC - 1));
  assign shift   = (st_q == ST_FAST) ? `ALZL_FAST_SHIFT
                 : `ALZL_RUN_SHIFT_BASE + {1'b0, cfg_q.avg_sel};
  assign pend    = tick && (scnt_q == 12'((12'h001 << shift) - 12'h001));
  assign sum_all = sum_q + {11'h000, code_s_q};
  assign avg_val = 8'(sum_all >> shift);

  always_comb
  begin
    st_d      = st_q;
    tick_d    = tick_q;
    scnt_d    = scnt_q;
    sum_d     = sum_q;
    fast_d    = fast_q;
    res_out_d = res_out_q;
    zstb_d    = 1'b0;
    unique case (st_q)
      ST_OFF:
      begin
        tick_d = 11'h000;
        scnt_d = 12'h000;
        sum_d  = 19'h00000;
        fast_d = 2'h0;
        if (cfg_q.enable)
        begin
          st_d           = ST_FAST;
          res_out_d.zone = 3'h0;
        end
      end
      ST_FAST, ST_RUN:
      begin
        tick_d = tick ? 11'h000 : tick_q + 11'h001;
        if (tick)
        begin
          res_out_d.raw = code_s_q;
          scnt_d        = scnt_q + 12'h001;
          sum_d         = sum_all;
        end
        if (pend)
        begin
          scnt_d         = 12'h000;
          sum_d          = 19'h00000;
          res_out_d.avg  = avg_val;
          res_out_d.zone = zone_next(res_out_q.zone, avg_val, hi_q, lo_q);
          zstb_d         = 1'b1;
          if (st_q == ST_FAST)
          begin
            fast_d = fast_q + 2'h1;
            if (fast_q == `ALZL_FAST_PERIODS - 2'h1)
              st_d = ST_RUN;
          end
        end
        if (!cfg_q.enable)
          st_d = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q      <= ST_OFF;
      tick_q    <= 11'h000;
      scnt_q    <= 12'h000;
      sum_q     <= 19'h00000;
      fast_q    <= 2'h0;
      res_out_q <= '0;
      zone_stb  <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      tick_q    <= tick_d;
      scnt_q    <= scnt_d;
      sum_q     <= sum_d;
      fast_q    <= fast_d;
      res_out_q <= res_out_d;
      zone_stb  <= zstb_d;
    end
  end

  // ----------------------------------------------------------------
  // zone target readout, one set per cycle
  // ----------------------------------------------------------------
  logic [1:0] rset_q, rset_d, rset_dly_q;
  logic [7:0] tgt_rd;
  logic [7:0] t1_d, t2_d, t3_d;

  alzl_target_mem u_tgt (
    .core_clk (core_clk),
    .nrst     (nrst),
    .wr_en    (tgt_we),
    .wr_addr  (tgt_waddr),
    .wr_data  (reg_wdata),
    .rd_addr  (4'(rset_q * 3'h5 + res_out_q.zone)),
    .rd_data  (tgt_rd)
  );

  always_comb
  begin
    rset_d = (rset_q == 2'h2) ? 2'h0 : rset_q + 2'h1;
    t1_d   = (rset_dly_q == 2'h0) ? tgt_rd : target_set_one;
    t2_d   = (rset_dly_q == 2'h1) ? tgt_rd : target_set_two;
    t3_d   = (rset_dly_q == 2'h2) ? tgt_rd : target_set_three;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rset_q           <= 2'h0;
      rset_dly_q       <= 2'h0;
      target_set_one   <= 8'h00;
      target_set_two   <= 8'h00;
      target_set_three <= 8'h00;
    end
    else
    begin
      rset_q           <= rset_d;
      rset_dly_q       <= rset_q;
      target_set_one   <= t1_d;
      target_set_two   <= t2_d;
      target_set_three <= t3_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign conv_run       = (st_q != ST_OFF);
  assign sample_stb     = tick;
  assign pwm_sense_mode = cfg_q.pwm_mode;
  assign gain_res_sel   = cfg_q.pwm_mode ? `ALZL_RES_HIZ : res_q;
  assign zone           = res_out_q.zone;
  assign zone_pwm_scale = pwmz_q[res_out_q.zone < 3'h5 ? res_out_q.zone : 3'h0];
  assign set_two_bank   = asg_q[2:0];
  assign set_three_bank = asg_q[6:4];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence fast_last_end;
    (st_q == ST_FAST) && pend && (fast_q == 2'h2);
  endsequence

  AST_PWM_HIZ: assert property (@(posedge core_clk) disable iff (!nrst)
    pwm_sense_mode |-> gain_res_sel == `ALZL_RES_HIZ)
    else $error("resistor not high impedance in pwm mode");

  AST_ZONE_RANGE: assert property (@(posedge core_clk) disable iff (!nrst)
    zone <= 3'h4)
    else $error("zone out of range");

  AST_ZONE_UP: assert property (@(posedge core_clk) disable iff (!nrst)
    pend && zone < 3'h4 && avg_val > hi_q[zone[1:0]] |=> zone > $past(zone))
    else $error("zone did not rise above upper threshold");

  AST_ZONE_DOWN: assert property (@(posedge core_clk) disable iff (!nrst)
    pend && zone > 3'h0 && avg_val < lo_q[2'(zone - 3'h1)]
      && !(zone < 3'h4 && avg_val > hi_q[zone[1:0]]) |=> zone < $past(zone))
    else $error("zone did not fall below lower threshold");

  AST_START_ZONE0: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_q == ST_OFF) && cfg_q.enable |=> (st_q == ST_FAST) && zone == 3'h0)
    else $error("startup did not begin in zone 0 fast phase");

  AST_SAMPLE_GAP: assert property (@(posedge core_clk) disable iff (!nrst)
    sample_stb |=> (!sample_stb)[*8] ##0 res_out_q.raw == $past(code_s_q, 8))
    else $error("raw sample not refreshed or strobes too close");

  AST_FAST_TO_RUN: assert property (@(posedge core_clk) disable iff (!nrst)
    fast_last_end and cfg_q.enable |=> st_q == ST_RUN)
    else $error("fast phase did not end after three periods");

  AST_FAST_SHIFT: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_q == ST_FAST) |-> shift == `ALZL_FAST_SHIFT)
    else $error("fast period not used in startup");

  AST_AVG_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    !pend |=> $stable(res_out_q.avg) && !zone_stb)
    else $error("average changed outside a period end");

  AST_OFF_IDLE: assert property (@(posedge core_clk) disable iff (!nrst)
    !conv_run |-> !sample_stb ##1 (conv_run || !sample_stb))
    else $error("sampling while converter stopped");

endmodule : alzl_core

`default_nettype wire

// *** logic/alzl_pkg.sv ***
// types shared by the light zone logic
package alzl_pkg;

  typedef enum logic [1:0] {ST_OFF, ST_FAST, ST_RUN} alzl_state_t;

  typedef logic [3:0][7:0] alzl_bound_t;

  typedef struct packed {
    logic       enable;
    logic       pwm_mode;
    logic [2:0] avg_sel;
  } alzl_cfg_t;

  typedef struct packed {
    logic [7:0] raw;
    logic [7:0] avg;
    logic [2:0] zone;
  } alzl_result_t;

endpackage : alzl_pkg

// *** logic/alzl_regs.svh ***
// register offsets, field positions and timing counts of the light zone logic
`ifndef ALZL_REGS_SVH
`define ALZL_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ALZL_OFS_CFG        8'h30
`define ALZL_OFS_RES_SEL    8'h31
`define ALZL_OFS_PWM_ZONE   8'h32
`define ALZL_OFS_SET_ASSIGN 8'h33
`define ALZL_OFS_RAW        8'h37
`define ALZL_OFS_AVG        8'h38
`define ALZL_OFS_ZONE       8'h39
`define ALZL_OFS_HI_BASE    8'h40
`define ALZL_OFS_LO_BASE    8'h44
`define ALZL_OFS_TGT_BASE   8'h50
`define ALZL_TGT_ENTRIES    8'h0f

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define ALZL_CFG_EN_BIT     0
`define ALZL_CFG_PWM_BIT    1
`define ALZL_CFG_AVG_LSB    3
`define ALZL_CFG_AVG_MSB    5
`define ALZL_CFG_RESET      8'h00
`define ALZL_RES_RESET      7'h00
`define ALZL_RES_HIZ        7'h00
`define ALZL_ASSIGN_RESET   8'h00
`define ALZL_ZONE_COUNT     5
`define ALZL_TOP_ZONE       3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ALZL_CLK_NS         100
`define ALZL_SAMPLE_NS      140000
`define ALZL_SAMPLE_CYC     (`ALZL_SAMPLE_NS / `ALZL_CLK_NS)
`define ALZL_FAST_SHIFT     4'h3
`define ALZL_RUN_SHIFT_BASE 4'h4
`define ALZL_FAST_PERIODS   2'h3

`endif

// *** logic/alzl_target_mem.sv ***
// zone target store: three sets of five 8-bit targets, registered read
`timescale 1ns/10ps
`default_nettype none

module alzl_target_mem
  import alzl_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [3:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] mem_q [0:14];
  logic [7:0] rd_data_d;

  always_comb
  begin
    rd_data_d = (rd_addr < 4'hf) ? mem_q[rd_addr] : 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (wr_en && wr_addr < 4'hf)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data <= 8'h00;
    end
    else
    begin
      rd_data <= rd_data_d;
    end
  end

endmodule : alzl_target_mem

`default_nettype wire

// *** verification/alzl_sensor_model.sv ***
// behavioural ambient light sensor and converter front end
`timescale 1ns/10ps
`default_nettype none

module alzl_sensor_model
(
  input  wire logic       core_clk,
  input  wire logic       conv_run,
  input  wire logic       pwm_sense_mode,
  input  wire logic [6:0] gain_res_sel,
  input  wire logic [7:0] level,
  output logic      [7:0] conv_code
);
  initial conv_code = 8'h5a;

  // ----------------------------------------------------------------
  // converter output
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (!conv_run)
      conv_code <= ~conv_code;  // idle converter: no valid code
    else if (pwm_sense_mode || gain_res_sel != 7'h00)
      conv_code <= level;
    else
      conv_code <= 8'hff;       // open input floats to the rail
  end
endmodule : alzl_sensor_model

`default_nettype wire

// *** verification/ambient_light_zone_logic_tb.sv ***
// self-checking testbench of the light zone core
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end

module ambient_light_zone_logic_tb;
  import alzl_pkg::*;

  logic        core_clk;
  logic        nrst;
  logic        reg_we;
  logic        reg_re;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [7:0]  conv_code;
  logic        conv_run;
  logic        sample_stb;
  logic [6:0]  gain_res_sel;
  logic        pwm_sense_mode;
  logic [2:0]  zone;
  logic        zone_stb;
  logic        zone_pwm_scale;
  logic [7:0]  target_set_one;
  logic [7:0]  target_set_two;
  logic [7:0]  target_set_three;
  logic [2:0]  set_two_bank;
  logic [2:0]  set_three_bank;
  logic [7:0]  level;
  logic [2:0]  exp_z;
  logic [31:0] seed;
  logic [7:0]  tg [3];
  logic [7:0]  hi_t [4];
  logic [7:0]  lo_t [4];
  int          err_count;
  int          checked;
  int          per_cnt;
  int          last_cyc;
  int          cyc;

  alzl_core i_alzl_core (
    .core_clk        (core_clk),
    .nrst            (nrst),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_we          (reg_we),
    .reg_re          (reg_re),
    .reg_rdata       (reg_rdata),
    .conv_code       (conv_code),
    .conv_run        (conv_run),
    .sample_stb      (sample_stb),
    .gain_res_sel    (gain_res_sel),
    .pwm_sense_mode  (pwm_sense_mode),
    .zone            (zone),
    .zone_stb        (zone_stb),
    .zone_pwm_scale  (zone_pwm_scale),
    .target_set_one  (target_set_one),
    .target_set_two  (target_set_two),
    .target_set_three(target_set_three),
    .set_two_bank    (set_two_bank),
    .set_three_bank  (set_three_bank)
  );

  alzl_sensor_model i_alzl_sensor_model (
    .core_clk      (core_clk),
    .conv_run      (conv_run),
    .pwm_sense_mode(pwm_sense_mode),
    .gain_res_sel  (gain_res_sel),
    .level         (level),
    .conv_code     (conv_code)
  );

  // ----------------------------------------------------------------
  // clock, monitor, helpers
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (!conv_run || zone_stb)
      per_cnt <= 0;
    if (!conv_run)
      last_cyc <= 0;
    if (sample_stb)
    begin
      `CHK("run_at_sample", 1'b1, conv_run)
      if (last_cyc > 0)
        `CHK("sample_gap", 1400, cyc - last_cyc)
      last_cyc <= cyc;
      per_cnt  <= per_cnt + 1;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [2:0] exp_zone(input logic [2:0] z, input logic [7:0] l);
    logic [2:0] n;
    n = z;
    while (n < 3'h4 && l > hi_t[n])
      n++;
    if (n == z)
      while (n > 3'h0 && l < lo_t[n - 1])
        n--;
    return n;
  endfunction : exp_zone

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge core_clk);
    reg_we    <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge core_clk);
    reg_re   <= 1'b0;
    @(negedge core_clk);
    `CHK(nm, ex, reg_rdata)
  endtask : rd_chk

  task automatic period(input logic [7:0] lv, input int n);
    int k;
    k = 0;
    exp_z = exp_zone(exp_z, lv);
    @(posedge core_clk);
    level <= lv;
    while (zone_stb !== 1'b1 && k < 30000)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k >= 30000)
    begin
      err_count++;
      $display("BAD period_end exp 1 got 0");
    end
    `CHK("zone", exp_z, zone)
    `CHK("period_len", n, per_cnt)
    rd_chk(8'h38, lv, "avg");
    rd_chk(8'h37, lv, "raw");
    rd_chk(8'h39, {5'h00, exp_z}, "zone_reg");
  endtask : period

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial
  begin
    #8_000_000;
    err_count++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    level = 8'h00;
    seed = 32'h7e11_812b;
    err_count = 0;
    checked = 0;
    per_cnt = 0;
    last_cyc = 0;
    cyc = 0;
    hi_t = '{8'h28, 8'h50, 8'h78, 8'ha0};
    lo_t = '{8'h1e, 8'h46, 8'h6e, 8'h96};
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    `CHK("zone_rst", 3'h0, zone)
    `CHK("run_rst", 1'b0, conv_run)
    rd_chk(8'h3f, 8'h00, "unmapped");
    rd_chk(8'h50, 8'h00, "target_read");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h40 + 8'(i), hi_t[i]);
      wr(8'h44 + 8'(i), lo_t[i]);
    end
    wr(8'h31, 8'h55);
    @(negedge core_clk);
    `CHK("res_sel", 7'h55, gain_res_sel)
    wr(8'h30, 8'h3a);
    @(negedge core_clk);
    `CHK("pwm_mode", 1'b1, pwm_sense_mode)
    `CHK("res_hiz", 7'h00, gain_res_sel)
    rd_chk(8'h30, 8'h3a, "cfg");
    wr(8'h30, 8'h00);
    @(negedge core_clk);
    `CHK("analog_mode", 1'b0, pwm_sense_mode)
    `CHK("res_back", 7'h55, gain_res_sel)
    wr(8'h32, 8'h04);
    wr(8'h33, 8'h42);
    @(negedge core_clk);
    `CHK("bank_two", 3'h2, set_two_bank)
    `CHK("bank_three", 3'h4, set_three_bank)
    for (int s = 0; s < 3; s++)
    begin
      seed = lfsr(seed);
      tg[s] = seed[7:0];
      wr(8'h52 + 8'(s * 5), tg[s]);
    end
    seed = lfsr(seed);
    level <= 8'(8'd170 + seed[7:0] % 8'd86);
    exp_z = 3'h0;
    wr(8'h30, 8'h01);
    repeat (2) @(negedge core_clk);
    `CHK("run_on", 1'b1, conv_run)
    `CHK("zone_start", 3'h0, zone)
    period(level, 8);
    period(8'h9b, 8);
    seed = lfsr(seed);
    period(seed[7:0] % 8'd30, 8);
    `CHK("pwm_scale_z0", 1'b0, zone_pwm_scale)
    seed = lfsr(seed);
    period(8'(8'd81 + seed[7:0] % 8'd29), 16);
    repeat (6) @(negedge core_clk);
    `CHK("pwm_scale_z2", 1'b1, zone_pwm_scale)
    `CHK("tgt_one", tg[0], target_set_one)
    `CHK("tgt_two", tg[1], target_set_two)
    `CHK("tgt_three", tg[2], target_set_three)
    wr(8'h30, 8'h00);
    repeat (2) @(negedge core_clk);
    `CHK("run_off", 1'b0, conv_run)
    give_verdict;
  end
endmodule : ambient_light_zone_logic_tb

`default_nettype wire
